/* design/cpw_clock_ctrl.sv */
// Clock mode, PLL, watchdog and sleep wake-up control of the
// microcontroller. Assumes the CPU core supplies instruction strobes
// and acts on deviceResetReq; clocks and pins arrive asynchronously.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
// What this block does
// - Control bit 0 enables the watchdog when 1, disables it when 0.
// - The watchdog-clear instruction restarts the watchdog count.
// - Watchdog counts its own oscillator, including during sleep.
// - Enabled watchdog time-out resets the device, awake or asleep.
// - Watchdog enable may change at any time in green or normal mode.
// - Without prescaler the watchdog period is about 18 ms.
// - Of main clock select bits 3 to 5 only bit 5 acts, and only in crystal mode.
// - PLL on, top select bit 0: normal mode at 3.582 MHz.
// - PLL on, top select bit 1: normal mode at 14.3 MHz.
// - Crystal mode, PLL off: green mode from 32768 Hz sub clock at the floor rate; select bit 5 still drives pllHighFreq.
// - PLL power bit 6 drives the PLL only in crystal mode; it sets sleep depth in every mode.
// - In sleep with bits 7,6 zero, timer time-outs never wake.
// - Watchdog time-out in that sleep resets, restarting at address 0.
// - Enabled port 7 pin 0, 1 or 3 wake in that sleep resets.
// - Pin 0 wake gated by mask bit 3, edge from edge select.
// - Pin 1 wake gated by mask bit 4, falling edge only.
// - Pin 3 wake gated by mask bit 7, falling edge only.
// - Pin 0 edge select: 0 both edges, 1 falling edge only.
// - Time-out flag set by sleep, clear and power-up; cleared by time-out.
module cpw_clock_ctrl #(
   parameter int WDT_RC_KHZ = cpw_pkg::WDT_RC_KHZ_DEFAULT,
   parameter int WDT_TIMEOUT_TICKS =
      cpw_pkg::WDT_TIMEOUT_US * WDT_RC_KHZ / 1000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [cpw_pkg::REG_ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   input wire cpw_pkg::cpw_osc_mode_type oscMode,
   input wire logic watchdogClearInstr,
   input wire logic sleepInstr,
   input wire logic wdtPrescaleOn,
   input wire logic [2:0] wdtPrescaleSel,
   input wire logic pin0EdgeSelect,
   input wire logic [7:0] interruptWakeMask,
   input wire logic timeBaseTimeout,
   input wire logic counter1Timeout,
   input wire logic [2:0] port7Pins,
   input wire logic subClkPin,
   input wire logic mainClkPin,
   input wire logic wdtOscPin,
   output logic cpuClk,
   output logic normalMode,
   output logic pllPowerOn,
   output logic pllHighFreq,
   output logic [15:0] mainClkKhz,
   output logic oscDriverOn,
   output logic sleeping,
   output logic deviceResetReq,
   output logic wakeResume,
   output logic timeOutFlag,
   output logic powerDownFlag
);
   cpw_pkg::cpw_ctrl_type ctrl;
   cpw_pkg::cpw_status_type status;
   cpw_pkg::cpw_src_type curSrc;
   cpw_pkg::cpw_src_type next_src;
   logic sleepDeep;
   logic crystal;
   logic wantMain;
   logic wdtTimeout;
   logic pinWake;
   logic timerWake;
   logic [cpw_pkg::PIN_COUNT-1:0] pinLevel;
   logic [cpw_pkg::PIN_COUNT-1:0] pinRise;
   logic [cpw_pkg::PIN_COUNT-1:0] pinFall;

   generate
      if (WDT_TIMEOUT_TICKS < 2) begin : g_bad
         $error("cpw_clock_ctrl needs a longer watchdog time-out");
      end
   endgenerate

   function automatic logic isCtrl(input logic [3:0] a);
      isCtrl = (a == cpw_pkg::ADDR_CTRL);
   endfunction

   cpw_pin_sync #(
      .WIDTH(cpw_pkg::PIN_COUNT)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .pinIn({wdtOscPin, mainClkPin, subClkPin, port7Pins}),
      .level(pinLevel),
      .rise(pinRise),
      .fall(pinFall)
   );

   cpw_watchdog #(
      .TIMEOUT_TICKS(WDT_TIMEOUT_TICKS)
   ) u_wdt (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .enable(ctrl.watchdogEnable),
      .clear(watchdogClearInstr),
      .tick(pinRise[cpw_pkg::PIN_WDT]),
      .prescaleOn(wdtPrescaleOn),
      .prescaleSel(wdtPrescaleSel),
      .timeout(wdtTimeout)
   );

   // Effective clock controls per oscillator mode
   always_comb begin
      crystal = (oscMode == cpw_pkg::OSC_CRYSTAL);
      wantMain = !crystal || ctrl.pllPowerEnable;
   end

   // Port 7 pin and timer wake sources
   always_comb begin
      pinWake = 1'b0;
      if (interruptWakeMask[cpw_pkg::MASK_PIN0]) begin
         pinWake = pinFall[cpw_pkg::PIN_P0] ||
            (!pin0EdgeSelect && pinRise[cpw_pkg::PIN_P0]);
      end
      if (interruptWakeMask[cpw_pkg::MASK_PIN1] &&
            pinFall[cpw_pkg::PIN_P1]) begin
         pinWake = 1'b1;
      end
      if (interruptWakeMask[cpw_pkg::MASK_PIN3] &&
            pinFall[cpw_pkg::PIN_P3]) begin
         pinWake = 1'b1;
      end
      timerWake =
         (interruptWakeMask[cpw_pkg::MASK_TBC] && timeBaseTimeout) ||
         (interruptWakeMask[cpw_pkg::MASK_CNT1] && counter1Timeout);
   end

   // Control register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl <= cpw_pkg::CTRL_RESET;
      end else if (ce) begin
         if (wdtTimeout || (sleeping && sleepDeep && pinWake)) begin
            ctrl <= cpw_pkg::CTRL_RESET;
         end else if (regWrite && isCtrl(regAddr)) begin
            ctrl <= regWdata;
            ctrl.unused <= 2'b00;
         end
      end
   end

   // Sleep entry, wake and device reset requests
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sleeping <= 1'b0;
         sleepDeep <= 1'b0;
         deviceResetReq <= 1'b0;
         wakeResume <= 1'b0;
      end else if (ce) begin
         deviceResetReq <= 1'b0;
         wakeResume <= 1'b0;
         if (wdtTimeout) begin
            deviceResetReq <= 1'b1;
            sleeping <= 1'b0;
         end else if (sleeping && sleepDeep && pinWake) begin
            deviceResetReq <= 1'b1;
            sleeping <= 1'b0;
         end else if (sleeping && !sleepDeep && (pinWake || timerWake)) begin
            wakeResume <= 1'b1;
            sleeping <= 1'b0;
         end else if (sleepInstr && !sleeping) begin
            sleeping <= 1'b1;
            sleepDeep <= !ctrl.spare7 && !ctrl.pllPowerEnable;
         end
      end
   end

   // Time-out and power-down flags; setting wins over clearing
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timeOutFlag <= 1'b1;
         powerDownFlag <= 1'b1;
      end else if (ce) begin
         if (sleepInstr || watchdogClearInstr) begin
            timeOutFlag <= 1'b1;
         end else if (wdtTimeout) begin
            timeOutFlag <= 1'b0;
         end
         if (watchdogClearInstr) begin
            powerDownFlag <= 1'b1;
         end else if (sleepInstr) begin
            powerDownFlag <= 1'b0;
         end
      end
   end

   // Source change only while both source levels are low
   always_comb begin
      next_src = curSrc;
      case (curSrc)
         cpw_pkg::SRC_SUB: begin
            if (wantMain && !pinLevel[cpw_pkg::PIN_SUB] &&
                  !pinLevel[cpw_pkg::PIN_MAIN]) begin
               next_src = cpw_pkg::SRC_MAIN;
            end
         end
         cpw_pkg::SRC_MAIN: begin
            if (!wantMain && !pinLevel[cpw_pkg::PIN_SUB] &&
                  !pinLevel[cpw_pkg::PIN_MAIN]) begin
               next_src = cpw_pkg::SRC_SUB;
            end
         end
         default: begin
            next_src = cpw_pkg::SRC_SUB;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         curSrc <= cpw_pkg::SRC_SUB;
         cpuClk <= 1'b0;
      end else if (ce) begin
         curSrc <= next_src;
         if (sleeping) begin
            cpuClk <= 1'b0;
         end else if (next_src == cpw_pkg::SRC_MAIN) begin
            cpuClk <= pinLevel[cpw_pkg::PIN_MAIN];
         end else begin
            cpuClk <= pinLevel[cpw_pkg::PIN_SUB];
         end
      end
   end

   // Mode and PLL outputs
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         normalMode <= 1'b0;
         pllPowerOn <= 1'b0;
         pllHighFreq <= 1'b0;
         mainClkKhz <= cpw_pkg::SUB_CLK_KHZ_FLOOR;
         oscDriverOn <= 1'b1;
      end else if (ce) begin
         normalMode <= wantMain;
         pllPowerOn <= crystal && ctrl.pllPowerEnable;
         pllHighFreq <= crystal && ctrl.mainClockSelect[2];
         oscDriverOn <= !sleeping;
         if (!crystal || !ctrl.pllPowerEnable) begin
            mainClkKhz <= cpw_pkg::SUB_CLK_KHZ_FLOOR;
         end else if (ctrl.mainClockSelect[2]) begin
            mainClkKhz <= cpw_pkg::PLL_HIGH_KHZ;
         end else begin
            mainClkKhz <= cpw_pkg::PLL_LOW_KHZ;
         end
      end
   end

   // Status word and register read port
   always_comb begin
      status = '0;
      status.timeOut = timeOutFlag;
      status.powerDown = powerDownFlag;
      status.normalMode = normalMode;
      status.sleeping = sleeping;
      status.mainSelected = (curSrc == cpw_pkg::SRC_MAIN);
      status.pllRunning = pllPowerOn;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regRdata <= cpw_pkg::READ_UNMAPPED;
      end else if (ce) begin
         regRdata <= cpw_pkg::READ_UNMAPPED;
         if (regRead && isCtrl(regAddr)) begin
            regRdata <= ctrl;
         end else if (regRead && regAddr == cpw_pkg::ADDR_STATUS) begin
            regRdata <= status;
         end
      end
   end
endmodule

/* design/cpw_pkg.sv */
// Constants, register map and carrier types of the clock, PLL, watchdog
// and wake-up control block.
// Assumes a single 100 MHz system clock and an 8-bit register port.
package cpw_pkg;
   localparam int CLK_MHZ = 100;
   localparam int WDT_TIMEOUT_US = 18000;
   localparam int WDT_RC_KHZ_DEFAULT = 1000;
   localparam logic [15:0] SUB_CLK_HZ = 16'h8000;
   localparam logic [15:0] PLL_LOW_KHZ = 16'h0DFE;
   localparam logic [15:0] PLL_HIGH_KHZ = 16'h37DC;
   localparam logic [15:0] SUB_CLK_KHZ_FLOOR = 16'h0020;

   localparam int REG_ADDR_W = 4;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   localparam int MASK_PIN0 = 3;
   localparam int MASK_PIN1 = 4;
   localparam int MASK_PIN3 = 7;
   localparam int MASK_TBC = 0;
   localparam int MASK_CNT1 = 1;

   localparam int PIN_P0 = 0;
   localparam int PIN_P1 = 1;
   localparam int PIN_P3 = 2;
   localparam int PIN_SUB = 3;
   localparam int PIN_MAIN = 4;
   localparam int PIN_WDT = 5;
   localparam int PIN_COUNT = 6;

   typedef struct packed {
      logic spare7;
      logic pllPowerEnable;
      logic [2:0] mainClockSelect;
      logic [1:0] unused;
      logic watchdogEnable;
   } cpw_ctrl_type;

   typedef struct packed {
      logic [1:0] zero;
      logic pllRunning;
      logic mainSelected;
      logic sleeping;
      logic normalMode;
      logic powerDown;
      logic timeOut;
   } cpw_status_type;

   typedef enum logic [2:0] {
      OSC_CRYSTAL = 3'b001,
      OSC_IRC = 3'b010,
      OSC_EXTERNAL_RESISTOR_RC_MODE = 3'b100
   } cpw_osc_mode_type;

   typedef enum logic [1:0] {
      SRC_SUB = 2'b01,
      SRC_MAIN = 2'b10
   } cpw_src_type;
endpackage

/* design/cpw_pin_sync.sv */
// Three-stage synchroniser with agreement filter and edge pulses.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/100ps
module cpw_pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   generate
      if (WIDTH < 1) begin : g_bad
         $error("cpw_pin_sync needs WIDTH of at least one");
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else if (ce) begin
         stage1 <= pinIn;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         // Level follows only once stages two and three agree
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               level[i] <= 1'b0;
               rise[i] <= 1'b0;
               fall[i] <= 1'b0;
            end else if (ce) begin
               rise[i] <= (stage2[i] == stage3[i]) && stage3[i] && !level[i];
               fall[i] <= (stage2[i] == stage3[i]) && !stage3[i] && level[i];
               if (stage2[i] == stage3[i]) begin
                  level[i] <= stage3[i];
               end
            end
         end
      end
   endgenerate
endmodule

/* design/cpw_watchdog.sv */
// Watchdog counter stepped by its own oscillator ticks, with optional
// power-of-two prescaler. Assumes tick is a one-cycle pulse on clk.
`timescale 1ns/100ps
module cpw_watchdog #(
   parameter int TIMEOUT_TICKS = 18000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic enable,
   input wire logic clear,
   input wire logic tick,
   input wire logic prescaleOn,
   input wire logic [2:0] prescaleSel,
   output logic timeout
);
   localparam int CW = $clog2(TIMEOUT_TICKS + 1);
   localparam logic [CW-1:0] LAST = CW'(TIMEOUT_TICKS - 1);

   logic [6:0] preCount;
   logic [CW-1:0] count;
   logic [6:0] preLast;
   logic step;

   generate
      if (TIMEOUT_TICKS < 2) begin : g_bad
         $error("cpw_watchdog needs TIMEOUT_TICKS of at least two");
      end
   endgenerate

   // Ratio 1:1 up to 1:128 from the three prescale bits
   always_comb begin
      preLast = 7'((8'h01 << prescaleSel) - 8'h01);
      step = tick && (!prescaleOn || (preCount == preLast));
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         preCount <= 7'h00;
      end else if (ce) begin
         if (clear || !enable || step) begin
            preCount <= 7'h00;
         end else if (tick) begin
            preCount <= 7'(preCount + 7'h01);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count <= '0;
         timeout <= 1'b0;
      end else if (ce) begin
         timeout <= 1'b0;
         if (clear || !enable) begin
            count <= '0;
         end else if (step) begin
            if (count == LAST) begin
               count <= '0;
               timeout <= 1'b1;
            end else begin
               count <= CW'(count + 1'b1);
            end
         end
      end
   end
endmodule

/* tb/cpw_clock_ctrl_sva.sv */
// Port checker for the clock, PLL, watchdog and wake block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module cpw_clock_ctrl_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire cpw_pkg::cpw_osc_mode_type oscMode,
   input wire logic normalMode,
   input wire logic pllPowerOn,
   input wire logic pllHighFreq,
   input wire logic [15:0] mainClkKhz,
   input wire logic sleeping,
   input wire logic deviceResetReq,
   input wire logic wakeResume,
   input wire logic timeOutFlag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_rst_once;
      deviceResetReq |=> !deviceResetReq;
   endproperty
   a_rst_once: assert property (p_rst_once)
      else $error("reset pulse too long");
   property p_tout_fall;
      $fell(timeOutFlag) |-> deviceResetReq;
   endproperty
   a_tout_fall: assert property (p_tout_fall)
      else $error("flag fell without time-out");
   property p_rc_ignore;
      oscMode != cpw_pkg::OSC_CRYSTAL |=> !pllPowerOn && !pllHighFreq;
   endproperty
   a_rc_ignore: assert property (p_rc_ignore)
      else $error("PLL active in RC mode");
   property p_pll_normal;
      pllPowerOn |-> normalMode;
   endproperty
   a_pll_normal: assert property (p_pll_normal)
      else $error("PLL on but green mode");
   property p_freq_on;
      pllPowerOn |-> mainClkKhz == (pllHighFreq ?
         cpw_pkg::PLL_HIGH_KHZ : cpw_pkg::PLL_LOW_KHZ);
   endproperty
   a_freq_on: assert property (p_freq_on)
      else $error("wrong main clock rate");
   property p_freq_off;
      !pllPowerOn |-> mainClkKhz == cpw_pkg::SUB_CLK_KHZ_FLOOR;
   endproperty
   a_freq_off: assert property (p_freq_off)
      else $error("rate shown with PLL off");
   property p_rst_wake;
      deviceResetReq && $past(sleeping) |-> !sleeping;
   endproperty
   a_rst_wake: assert property (p_rst_wake)
      else $error("still asleep after reset");
   property p_wake_only;
      wakeResume |-> $past(sleeping) && !sleeping;
   endproperty
   a_wake_only: assert property (p_wake_only)
      else $error("resume outside sleep");
   c_wdt: cover property (deviceResetReq && !$past(sleeping));
   c_deep: cover property (deviceResetReq && $past(sleeping));
   c_resume: cover property (wakeResume);
endmodule

/* tb/cpw_far_model.sv */
// Far side: free-running oscillators and wake pins driven from pinCmd.
// Assumes the bench sets wanted pin levels on pinCmd.
`timescale 1ns/100ps
module cpw_far_model #(
   parameter real WDT_HALF_NS = 203.0
) (
   input wire logic [2:0] pinCmd,
   output logic [2:0] port7Pins,
   output logic subClkPin = 1'h0,
   output logic mainClkPin = 1'h0,
   output logic wdtOscPin = 1'h0
);
   always #(WDT_HALF_NS) wdtOscPin = ~wdtOscPin;
   always #157.3 subClkPin = ~subClkPin;
   always #31.7 mainClkPin = ~mainClkPin;
   assign port7Pins = pinCmd;
endmodule

/* tb/cpw_clock_ctrl_tb.sv */
// Self-checking bench for the clock, PLL, watchdog and wake block.
// Assumes the far-side model drives oscillators and wake pins.
`timescale 1ns/100ps
module cpw_clock_ctrl_tb;
   localparam int TICKS = 8;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWdata = 8'h00;
   logic regWrite = 1'h0;
   logic regRead = 1'h0;
   logic [7:0] regRdata;
   cpw_pkg::cpw_osc_mode_type oscMode = cpw_pkg::OSC_CRYSTAL;
   logic clrInstr = 1'h0;
   logic sleepInstr = 1'h0;
   logic edgeSel = 1'h0;
   logic [7:0] wakeMask = 8'h00;
   logic tbTo = 1'h0;
   logic c1To = 1'h0;
   logic [2:0] pinCmd = 3'h7;
   logic [2:0] pins;
   logic subClk, mainClk, wdtOsc, cpuClk, normalMode, pllPowerOn;
   logic pllHighFreq, oscDriverOn, sleeping, devRst, wakeResume, tFlag;
   logic pdFlag;
   logic [15:0] mainClkKhz;
   int badCount = 0;
   int comparisons = 0;
   always #5 clk = ~clk;
   cpw_far_model far (.pinCmd(pinCmd), .port7Pins(pins),
      .subClkPin(subClk), .mainClkPin(mainClk), .wdtOscPin(wdtOsc));
   cpw_clock_ctrl #(.WDT_TIMEOUT_TICKS(TICKS)) dut (.clk(clk),
      .rst_n(rst_n), .ce(1'h1), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .oscMode(oscMode), .watchdogClearInstr(clrInstr),
      .sleepInstr(sleepInstr), .wdtPrescaleOn(1'h0),
      .wdtPrescaleSel(3'h0), .pin0EdgeSelect(edgeSel),
      .interruptWakeMask(wakeMask), .timeBaseTimeout(tbTo),
      .counter1Timeout(c1To), .port7Pins(pins), .subClkPin(subClk),
      .mainClkPin(mainClk), .wdtOscPin(wdtOsc), .cpuClk(cpuClk),
      .normalMode(normalMode), .pllPowerOn(pllPowerOn),
      .pllHighFreq(pllHighFreq), .mainClkKhz(mainClkKhz),
      .oscDriverOn(oscDriverOn), .sleeping(sleeping),
      .deviceResetReq(devRst), .wakeResume(wakeResume),
      .timeOutFlag(tFlag), .powerDownFlag(pdFlag));
   task automatic reportAndStop();
      if (badCount == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         badCount++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'h1;
      @(posedge clk);
      regWrite <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'h1;
      @(posedge clk);
      regRead <= 1'h0;
      #1 chk({8'h00, regRdata}, {8'h00, e});
   endtask
   // Waits a bounded time for a reset or resume pulse
   task automatic waitPulse(input int n, input logic wantRst);
      #1;
      repeat (n) begin
         if ((wantRst ? devRst : wakeResume) === 1'h1) begin
            chk({15'h0, sleeping}, 16'h0);
            return;
         end
         @(posedge clk);
         #1;
      end
      $display("unexpected at %0t: no pulse", $time);
      badCount++;
      reportAndStop();
   endtask
   task automatic quiet(input int n);
      repeat (n) begin
         @(posedge clk);
         #1 chk({14'h0, devRst, wakeResume}, 16'h0);
      end
   endtask
   task automatic strobe(input logic s, input logic t);
      @(posedge clk);
      sleepInstr <= s;
      clrInstr <= !s && !t;
      tbTo <= t;
      c1To <= t;
      @(posedge clk);
      sleepInstr <= 1'h0;
      clrInstr <= 1'h0;
      tbTo <= 1'h0;
      c1To <= 1'h0;
   endtask
   task automatic doze(input logic [7:0] c, input logic [7:0] m,
      input logic e, input logic [2:0] p);
      wr(cpw_pkg::ADDR_CTRL, c);
      wakeMask <= m;
      edgeSel <= e;
      pinCmd <= p;
      repeat (10) @(posedge clk);
      strobe(1'h1, 1'h0);
      repeat (3) @(posedge clk);
      #1 chk({12'h0, sleeping, oscDriverOn, cpuClk, pdFlag}, 16'h8);
   endtask
   task automatic tRegs();
      rd(cpw_pkg::ADDR_CTRL, 8'h00);
      rd(cpw_pkg::ADDR_STATUS, 8'h03);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
      wr(cpw_pkg::ADDR_CTRL, 8'h7F);
      rd(cpw_pkg::ADDR_CTRL, 8'h79);
   endtask
   task automatic tClock();
      logic [7:0] cv[5] = '{8'h40, 8'h58, 8'h60, 8'h78, 8'h38};
      cpw_pkg::cpw_osc_mode_type rc[2] = '{cpw_pkg::OSC_IRC,
         cpw_pkg::OSC_EXTERNAL_RESISTOR_RC_MODE};
      logic [15:0] f;
      for (int i = 0; i < 5; i++) begin
         wr(cpw_pkg::ADDR_CTRL, cv[i]);
         repeat (3) @(posedge clk);
         f = !cv[i][6] ? cpw_pkg::SUB_CLK_KHZ_FLOOR
            : cv[i][5] ? cpw_pkg::PLL_HIGH_KHZ : cpw_pkg::PLL_LOW_KHZ;
         #1 chk(mainClkKhz, f);
         chk({pllHighFreq, pllPowerOn, normalMode},
            {cv[i][5], cv[i][6], cv[i][6]});
      end
      for (int i = 0; i < 2; i++) begin
         oscMode <= rc[i];
         wr(cpw_pkg::ADDR_CTRL, 8'h78);
         repeat (3) @(posedge clk);
         #1 chk(mainClkKhz, cpw_pkg::SUB_CLK_KHZ_FLOOR);
         chk({pllHighFreq, pllPowerOn, normalMode}, 16'h1);
      end
      oscMode <= cpw_pkg::OSC_CRYSTAL;
   endtask
   task automatic tWatchdog();
      wr(cpw_pkg::ADDR_CTRL, 8'h01);
      quiet(250);
      waitPulse(200, 1'h1);
      chk({15'h0, tFlag}, 16'h0);
      rd(cpw_pkg::ADDR_CTRL, 8'h00);
      wr(cpw_pkg::ADDR_CTRL, 8'h41);
      repeat (8) begin
         quiet(100);
         strobe(1'h0, 1'h0);
      end
      #1 chk({15'h0, tFlag}, 16'h1);
      wr(cpw_pkg::ADDR_CTRL, 8'h40);
      quiet(TICKS * 60);
   endtask
   task automatic tSleep();
      doze(8'h00, 8'h13, 1'h0, 3'h7);
      strobe(1'h0, 1'h1);
      quiet(20);
      pinCmd <= 3'h5;
      waitPulse(20, 1'h1);
      doze(8'h00, 8'h80, 1'h0, 3'h7);
      pinCmd <= 3'h5;
      quiet(20);
      pinCmd <= 3'h1;
      waitPulse(20, 1'h1);
      doze(8'h00, 8'h08, 1'h1, 3'h6);
      pinCmd <= 3'h7;
      quiet(20);
      pinCmd <= 3'h6;
      waitPulse(20, 1'h1);
      doze(8'h00, 8'h08, 1'h0, 3'h6);
      pinCmd <= 3'h7;
      waitPulse(20, 1'h1);
      doze(8'h40, 8'h01, 1'h0, 3'h7);
      strobe(1'h0, 1'h1);
      waitPulse(5, 1'h0);
      doze(8'h01, 8'h00, 1'h0, 3'h7);
      waitPulse(TICKS * 60, 1'h1);
      chk({15'h0, tFlag}, 16'h0);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      tRegs();
      tClock();
      tWatchdog();
      tSleep();
      reportAndStop();
   end
endmodule
bind cpw_clock_ctrl cpw_clock_ctrl_sva chk_i (.clk(clk), .rst_n(rst_n),
   .oscMode(oscMode), .normalMode(normalMode), .pllPowerOn(pllPowerOn),
   .pllHighFreq(pllHighFreq), .mainClkKhz(mainClkKhz),
   .sleeping(sleeping), .deviceResetReq(deviceResetReq),
   .wakeResume(wakeResume), .timeOutFlag(timeOutFlag));
